// ===== logic/ssp_port.v
/*
 * Synchronous half-duplex serial port: master and slave reception and
 * transmission on a shift clock line and a serial data line, with an
 * APB register slave, a baud divider for master clocking and a one-word
 * transmit buffer ahead of the shift register.
 * Assumes: mclk_in at 200 MHz; pins arrive asynchronously and are
 * synchronised here; sleep_in comes from logic on mclk_in; the pin pads
 * resolve the wires from the active-low output enables.
 */
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_port (
   input  wire        mclk_in,      // System clock, 200 MHz
   input  wire        nrst_in,      // Asynchronous reset, active low
   input  wire        ce_in,        // Clock enable, freezes all state but the reset release when low
   input  wire        sleep_in,     // Processor in a low-power or idle state
   input  wire        psel_in,      // APB select
   input  wire        penable_in,   // APB access phase
   input  wire        pwrite_in,    // APB direction, high for write
   input  wire [7:0]  paddr_in,     // APB byte address
   input  wire [31:0] pwdata_in,    // APB write data
   output reg  [31:0] prdata_out,   // APB read data
   output reg         pready_out,   // APB ready
   output reg         pslverr_out,  // APB error on unmapped address
   input  wire        ck_in,        // Shift clock line, pin level
   output reg         ck_out,       // Shift clock line, driven level
   output reg         ck_oe_n_out,  // Shift clock drive enable, active low
   input  wire        dt_in,        // Serial data line, pin level
   output reg         dt_out,       // Serial data line, driven level
   output reg         dt_oe_n_out,  // Serial data drive enable, active low
   output reg         wake_out,     // Enabled event pending, wakes processor
   output reg         irq_out       // Enabled event pending with global enables
);

   localparam ST_IDLE = 2'b00;      // Nothing shifting
   localparam ST_RX   = 2'b01;      // Receiving a word
   localparam ST_DONE = 2'b10;      // Handing a received word over
   localparam ST_TX   = 2'b11;      // Transmitting a word

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   reg         rst_s1;              // Reset release, first stage
   reg         rst_n;               // Reset release, used by the design
   reg         ck_s1, ck_s2;        // Clock pin synchroniser
   reg         dt_s1, dt_s2;        // Data pin synchroniser
   reg         ck_prev;             // Last logical slave clock level
   // Receive status and control
   reg         serial_port_enable;
   reg         nine_bit_receive_select;
   reg         single_receive_enable;
   reg         continuous_receive_enable;
   reg         overrun_error_flag;
   reg         received_ninth_bit;
   reg  [7:0]  receive_buffer;
   reg         receive_complete_flag;
   // Transmit status and control
   reg         clock_source_select;
   reg         nine_bit_transmit_select;
   reg         transmitter_enable;
   reg         sync_mode;
   reg         transmit_ninth_bit;
   reg  [7:0]  transmit_buffer;
   reg         tx_full;             // Buffer holds a word not yet shifted
   // Rate, polarity and interrupt control
   reg         clock_polarity_select;
   reg         sixteen_bit_divider_select;
   reg  [7:0]  baud_divider_high;
   reg  [7:0]  baud_divider_low;
   reg         receive_irq_enable;
   reg         transmit_irq_enable;
   reg         global_irq_enable;
   reg         peripheral_irq_enable;
   // Shift engine
   reg  [1:0]  state;               // Engine state
   reg  [8:0]  transmit_shift_register;
   reg  [8:0]  rx_shift;            // Bits gathered so far
   reg  [3:0]  bit_cnt;             // Bits finished in this word
   reg         sck;                 // Master clock, logical (idle low)
   reg  [15:0] brg_cnt;             // Divider countdown
   reg  [31:0] next_rdata;          // Read mux
   reg         next_err;            // Unmapped address

   wire        framing_error_flag = 1'b0;         // Synchronous frames carry no stop bit
   wire        apb_go   = psel_in & penable_in & pready_out;
   wire        wr       = apb_go & pwrite_in;
   wire        rd       = apb_go & ~pwrite_in;
   wire        master   = clock_source_select;
   wire        active   = serial_port_enable & sync_mode;
   // Slave receive ignores the single enable; continuous wins when both set
   wire        rx_en    = active & ~overrun_error_flag &
                          (continuous_receive_enable |
                           (master & single_receive_enable));
   // Master work halts with the processor clock; slave runs on the pin clock
   wire        run      = ~sleep_in | ~master;
   wire [15:0] div      = sixteen_bit_divider_select ?
                          {baud_divider_high, baud_divider_low} :
                          {8'h00, baud_divider_low};
   wire        busy     = (state == ST_RX) | (state == ST_TX);
   wire        tick     = run & master & busy & (brg_cnt == 16'h0000);
   wire        ck_lvl   = ck_s2 ^ clock_polarity_select;
   wire        rise     = master ? (tick & ~sck) : (run & ck_lvl & ~ck_prev);
   wire        fall     = master ? (tick & sck)  : (run & ~ck_lvl & ck_prev);
   wire        rx_nine  = nine_bit_receive_select;
   wire        tx_nine  = nine_bit_transmit_select;
   wire [3:0]  rx_last  = rx_nine ? 4'h8 : 4'h7;
   wire [3:0]  tx_last  = tx_nine ? 4'h8 : 4'h7;
   wire        sr_empty = (state != ST_TX);
   wire        tx_load  = (state == ST_IDLE) & ~rx_en & active & transmitter_enable
                          & tx_full & run;
   wire        transmit_buffer_empty_flag     = ~tx_full;
   wire        pending  = (receive_complete_flag & receive_irq_enable) |
                          (transmit_buffer_empty_flag & transmit_irq_enable);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read by logic
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         dt_s1 <= 1'b0;
         dt_s2 <= 1'b0;
      end else if (ce_in) begin
         ck_s1 <= ck_in;
         ck_s2 <= ck_s1;
         dt_s1 <= dt_in;
         dt_s2 <= dt_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; bits with no field read as zero
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (paddr_in)
         `SSP_OFF_RCV_STATUS: begin
            next_rdata[`SSP_RS_PORT_EN]   = serial_port_enable;
            next_rdata[`SSP_RS_RX9]       = nine_bit_receive_select;
            next_rdata[`SSP_RS_SINGLE]    = single_receive_enable;
            next_rdata[`SSP_RS_CONT]      = continuous_receive_enable;
            next_rdata[`SSP_RS_FRAME_ERR] = framing_error_flag;
            next_rdata[`SSP_RS_OVERRUN]   = overrun_error_flag;
            next_rdata[`SSP_RS_NINTH]     = received_ninth_bit;
         end
         `SSP_OFF_RCV_BUFFER: next_rdata[7:0] = receive_buffer;
         `SSP_OFF_XMT_STATUS: begin
            next_rdata[`SSP_TS_CLK_SRC]  = clock_source_select;
            next_rdata[`SSP_TS_TX9]      = nine_bit_transmit_select;
            next_rdata[`SSP_TS_TX_EN]    = transmitter_enable;
            next_rdata[`SSP_TS_SYNC]     = sync_mode;
            next_rdata[`SSP_TS_SR_EMPTY] = sr_empty;
            next_rdata[`SSP_TS_NINTH]    = transmit_ninth_bit;
         end
         `SSP_OFF_RATE_POL: begin
            next_rdata[`SSP_RP_CLK_POL] = clock_polarity_select;
            next_rdata[`SSP_RP_DIV16]   = sixteen_bit_divider_select;
         end
         `SSP_OFF_DIV_HIGH:   next_rdata[7:0] = baud_divider_high;
         `SSP_OFF_DIV_LOW:    next_rdata[7:0] = baud_divider_low;
         `SSP_OFF_XMT_BUFFER: next_rdata[7:0] = transmit_buffer;
         `SSP_OFF_IRQ_CTRL: begin
            next_rdata[`SSP_IC_GLOBAL_EN] = global_irq_enable;
            next_rdata[`SSP_IC_PERIPH_EN] = peripheral_irq_enable;
            next_rdata[`SSP_IC_RX_IE]     = receive_irq_enable;
            next_rdata[`SSP_IC_TX_IE]     = transmit_irq_enable;
            next_rdata[`SSP_IC_RX_FLAG]   = receive_complete_flag;
            next_rdata[`SSP_IC_TX_FLAG]   = transmit_buffer_empty_flag;
         end
         default: next_err = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait state, so data and error come from flops
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (ce_in) begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         prdata_out  <= (psel_in & penable_in & ~pready_out & ~pwrite_in) ?
                        next_rdata : 32'h0000_0000;
         pslverr_out <= psel_in & penable_in & ~pready_out & next_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software-written registers; hardware updates ahead, writes last
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         serial_port_enable         <= 1'b0;
         nine_bit_receive_select    <= 1'b0;
         single_receive_enable      <= 1'b0;
         continuous_receive_enable  <= 1'b0;
         clock_source_select        <= 1'b0;
         nine_bit_transmit_select   <= 1'b0;
         transmitter_enable         <= 1'b0;
         sync_mode                  <= 1'b0;
         transmit_ninth_bit         <= 1'b0;
         clock_polarity_select      <= 1'b0;
         sixteen_bit_divider_select <= 1'b0;
         baud_divider_high          <= `SSP_RST_BYTE;
         baud_divider_low           <= `SSP_RST_BYTE;
         transmit_buffer            <= `SSP_RST_BYTE;
         receive_irq_enable         <= 1'b0;
         transmit_irq_enable        <= 1'b0;
         global_irq_enable          <= 1'b0;
         peripheral_irq_enable      <= 1'b0;
      end else if (ce_in) begin
         // Single word done: drop the enable unless continuous also set
         if (state == ST_DONE && !continuous_receive_enable)
            single_receive_enable <= 1'b0;
         if (wr) begin
            case (paddr_in)
               `SSP_OFF_RCV_STATUS: begin
                  serial_port_enable        <= pwdata_in[`SSP_RS_PORT_EN];
                  nine_bit_receive_select   <= pwdata_in[`SSP_RS_RX9];
                  single_receive_enable     <= pwdata_in[`SSP_RS_SINGLE];
                  continuous_receive_enable <= pwdata_in[`SSP_RS_CONT];
               end
               `SSP_OFF_XMT_STATUS: begin
                  clock_source_select      <= pwdata_in[`SSP_TS_CLK_SRC];
                  nine_bit_transmit_select <= pwdata_in[`SSP_TS_TX9];
                  transmitter_enable       <= pwdata_in[`SSP_TS_TX_EN];
                  sync_mode                <= pwdata_in[`SSP_TS_SYNC];
                  transmit_ninth_bit       <= pwdata_in[`SSP_TS_NINTH];
               end
               `SSP_OFF_RATE_POL: begin
                  clock_polarity_select      <= pwdata_in[`SSP_RP_CLK_POL];
                  sixteen_bit_divider_select <= pwdata_in[`SSP_RP_DIV16];
               end
               `SSP_OFF_DIV_HIGH:   baud_divider_high <= pwdata_in[7:0];
               `SSP_OFF_DIV_LOW:    baud_divider_low  <= pwdata_in[7:0];
               `SSP_OFF_XMT_BUFFER: transmit_buffer   <= pwdata_in[7:0];
               `SSP_OFF_IRQ_CTRL: begin
                  global_irq_enable     <= pwdata_in[`SSP_IC_GLOBAL_EN];
                  peripheral_irq_enable <= pwdata_in[`SSP_IC_PERIPH_EN];
                  receive_irq_enable    <= pwdata_in[`SSP_IC_RX_IE];
                  transmit_irq_enable   <= pwdata_in[`SSP_IC_TX_IE];
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Hardware flags: complete flag, overrun, buffer occupancy
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         receive_complete_flag <= 1'b0;
         overrun_error_flag    <= 1'b0;
         received_ninth_bit    <= 1'b0;
         receive_buffer        <= `SSP_RST_BYTE;
         tx_full               <= 1'b0;
      end else if (ce_in) begin
         // Reading the buffer clears the flag; a word landing now wins
         if (rd && paddr_in == `SSP_OFF_RCV_BUFFER)
            receive_complete_flag <= 1'b0;
         // Clearing the continuous enable clears the error
         if (wr && paddr_in == `SSP_OFF_RCV_STATUS && !pwdata_in[`SSP_RS_CONT])
            overrun_error_flag <= 1'b0;
         if (state == ST_DONE) begin
            if (receive_complete_flag &&
                !(rd && paddr_in == `SSP_OFF_RCV_BUFFER)) begin
               overrun_error_flag <= 1'b1;     // Unread word kept, new one lost
            end else begin
               receive_buffer        <= rx_shift[7:0];
               received_ninth_bit    <= rx_nine & rx_shift[8];
               receive_complete_flag <= 1'b1;
            end
         end
         // Transfer empties the buffer; a write in the same cycle refills it
         if (tx_load)
            tx_full <= 1'b0;
         if (wr && paddr_in == `SSP_OFF_XMT_BUFFER)
            tx_full <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shift engine and master clock generator
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         state                   <= ST_IDLE;
         transmit_shift_register <= `SSP_RST_WORD;
         rx_shift                <= `SSP_RST_WORD;
         bit_cnt                 <= 4'h0;
         sck                     <= 1'b0;
         brg_cnt                 <= `SSP_RST_DIV;
         ck_prev                 <= 1'b0;
         dt_out                  <= 1'b0;
      end else if (ce_in) begin
         ck_prev <= ck_lvl;
         // Master clock toggles every div+1 cycles, only while shifting
         if (!busy || !master) begin
            brg_cnt <= div;
            sck     <= 1'b0;
         end else if (run) begin
            if (tick) begin
               brg_cnt <= div;
               sck     <= ~sck;
            end else begin
               brg_cnt <= brg_cnt - 16'h0001;
            end
         end
         case (state)
            ST_IDLE: begin
               bit_cnt <= 4'h0;
               rx_shift <= `SSP_RST_WORD;
               if (rx_en && run) begin
                  state <= ST_RX;
               end else if (tx_load) begin
                  transmit_shift_register <= {tx_nine & transmit_ninth_bit,
                                              transmit_buffer};
                  state <= ST_TX;
               end
            end
            ST_RX: begin
               if (!rx_en) begin
                  state <= ST_IDLE;                  // Enable withdrawn mid-word
               end else if (fall) begin
                  rx_shift[bit_cnt] <= dt_s2;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == rx_last)
                     state <= ST_DONE;
               end
            end
            ST_DONE: begin
               // Back to idle; continuous mode starts the next word from there
               state <= ST_IDLE;
            end
            ST_TX: begin
               if (rise)
                  dt_out <= transmit_shift_register[bit_cnt];
               if (fall) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == tx_last)
                     state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive and wake/interrupt outputs, all from flops
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ck_out      <= 1'b0;
         ck_oe_n_out <= 1'b1;
         dt_oe_n_out <= 1'b1;
         wake_out    <= 1'b0;
         irq_out     <= 1'b0;
      end else if (ce_in) begin
         // Idle level follows the polarity bit; inversion in both modes
         ck_out      <= sck ^ clock_polarity_select;
         ck_oe_n_out <= ~(active & master);
         // Data driven whenever the port is active and the transmitter enabled, never while receiving
         dt_oe_n_out <= ~(active & transmitter_enable & ~rx_en &
                          (state != ST_RX));
         wake_out    <= pending;
         irq_out     <= pending & global_irq_enable &
                        peripheral_irq_enable;
      end
   end

endmodule // ssp_port

// ===== logic/ssp_defines.vh
/*
 * Register map, field positions and reset values of the synchronous
 * serial port. Definitions only; included by the port's design file.
 * Assumes a 32-bit APB data path with one aligned word per register.
 */
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets of the registers
`define SSP_OFF_RCV_STATUS   8'h00
`define SSP_OFF_RCV_BUFFER   8'h04
`define SSP_OFF_XMT_STATUS   8'h08
`define SSP_OFF_RATE_POL     8'h0c
`define SSP_OFF_DIV_HIGH     8'h10
`define SSP_OFF_DIV_LOW      8'h14
`define SSP_OFF_XMT_BUFFER   8'h18
`define SSP_OFF_IRQ_CTRL     8'h1c

////////////////////////////////////////////////////////////////////////////////
// Receive status and control fields
`define SSP_RS_PORT_EN       7
`define SSP_RS_RX9           6
`define SSP_RS_SINGLE        5
`define SSP_RS_CONT          4
`define SSP_RS_FRAME_ERR     2
`define SSP_RS_OVERRUN       1
`define SSP_RS_NINTH         0

// Transmit status and control fields
`define SSP_TS_CLK_SRC       7
`define SSP_TS_TX9           6
`define SSP_TS_TX_EN         5
`define SSP_TS_SYNC          4
`define SSP_TS_SR_EMPTY      1
`define SSP_TS_NINTH         0

// Rate and polarity fields
`define SSP_RP_CLK_POL       4
`define SSP_RP_DIV16         3

// Interrupt control fields
`define SSP_IC_GLOBAL_EN     7
`define SSP_IC_PERIPH_EN     6
`define SSP_IC_RX_IE         5
`define SSP_IC_TX_IE         4
`define SSP_IC_RX_FLAG       1
`define SSP_IC_TX_FLAG       0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define SSP_RST_BYTE         8'h00
`define SSP_RST_DIV          16'h0000
`define SSP_RST_WORD         9'h000

`endif

// ===== tb/ssp_port_assertions.sv
/* Checker for the bus answer and event outputs of the serial port.
   Sees only top-level ports; bound to every ssp_port at the foot. */
`timescale 1ns/1ps
module ssp_chk (
   input wire        mclk_in, nrst_in, psel_in, penable_in, // Clock, reset, request
   input wire        pready_out, pslverr_out, wake_out, irq_out, // Answer, events
   input wire [31:0] prdata_out // Read data
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // Setup, access, then the answer one cycle on
   property p_lat; psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out; endproperty
   a_lat: assert property (p_lat) else $error("ready not on time");
   property p_pulse; pready_out |=> !pready_out; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
   property p_hold; pready_out |-> psel_in && penable_in; endproperty
   a_hold: assert property (p_hold) else $error("ready outside an access");
   property p_err; pslverr_out |-> pready_out; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_errz; pslverr_out |-> prdata_out == 32'h0; endproperty
   a_errz: assert property (p_errz) else $error("refused read not zero");
   property p_idle; !pready_out |-> prdata_out == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_upper; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_irq; irq_out |-> wake_out; endproperty
   a_irq: assert property (p_irq) else $error("vector without wake");
   c_irq: cover property (irq_out);
   c_err: cover property (pslverr_out);
   c_wake: cover property ($rose(wake_out));
endmodule // ssp_chk
bind ssp_port ssp_chk i_ssp_chk (.mclk_in, .nrst_in, .psel_in, .penable_in, .pready_out,
   .pslverr_out, .wake_out, .irq_out, .prdata_out);

// ===== tb/ssp_peer.sv
/* Far-side model: a slave shifting a word out on the clock it gets, and a
   master clocking nine bits in at 125 ns. The bench resolves the wires. */
`timescale 1ns/1ps
module ssp_peer (
   input  wire logic       mclk_in, go_in, pol_in, ck_in, dt_in, // Clock, start, wires
   input  wire logic [8:0] word_in,        // Word sent as slave
   output logic            ck_out = 1'b0,  // Clock driven as master
   output logic            dt_out = 1'b0,  // Data driven as slave
   output logic [8:0]      word_out = 9'h0, // Word taken as master
   output logic            busy_out = 1'b0 // Frame running
);
   logic       lc = 1'b0; // Last logical clock
   logic [3:0] idx = 4'h0; // Next bit to send
   logic [7:0] q = 8'h0; // Cycles since a logical rise
   logic       gl = 1'b0; // Last start level seen
   // Next bit on each rise, steady at the fall; stale level never held
   always @(posedge mclk_in) begin
      lc <= ck_in ^ pol_in;
      q <= (q == 8'hff) ? q : q + 8'h01;
      if ((ck_in ^ pol_in) && !lc) begin
         dt_out <= word_in[idx];
         idx <= (idx == 4'h8) ? 4'h0 : idx + 4'h1;
         q <= 8'h00;
      end else begin
         if (q > 8'h0c) dt_out <= ~dt_out;
         if (q > 8'h28) idx <= 4'h0;
      end
   end
   // Clock stands at the idle level between frames; one process drives it
   always @(pol_in or go_in) begin
      ck_out = pol_in;
      if (go_in !== gl) begin
         gl = go_in;
         busy_out = 1'b1;
         #1.3;
         repeat (9) begin
            #62.5 ck_out = ~pol_in;
            #62.5 ck_out = pol_in;
            word_out = {dt_in, word_out[8:1]}; // Sampled at the fall, first bit lowest
         end
         busy_out = 1'b0;
      end
   end
endmodule // ssp_peer

// ===== tb/ssp_port_tb_top.sv
/* Bench: APB tasks reach the registers, the peer stands on the pins.
   Assumes the port, its defines, the peer and the checker are compiled. */
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_port_tb_top;
   logic        mclk_in = 0, nrst_in = 0, slp = 0, psel = 0, pen = 0, pwr = 0, go = 0, pol = 0;
   logic [7:0]  pa = 0; // Bus address
   logic [31:0] pwd = 0, q, prd; // Write, taken and live read data
   logic [8:0]  pw = 0, rxw; // Peer words
   logic        cko, ckn, dto, dtn, pck, pdt, rdy, err, wake, irq, e, busy;
   int          mismatches = 0, checks_done = 0, cyc = 0;
   wire         ck_pin = ckn ? pck : cko; // Resolved clock wire
   wire         dt_pin = dtn ? pdt : dto; // Resolved data wire
   always #2.5 mclk_in = ~mclk_in;
   ssp_port i_ssp_port (.mclk_in, .nrst_in, .ce_in(1'b1), .sleep_in(slp), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
      .pready_out(rdy), .pslverr_out(err), .ck_in(ck_pin), .ck_out(cko), .ck_oe_n_out(ckn),
      .dt_in(dt_pin), .dt_out(dto), .dt_oe_n_out(dtn), .wake_out(wake), .irq_out(irq));
   ssp_peer i_ssp_peer (.mclk_in, .go_in(go), .pol_in(pol), .ck_in(ck_pin), .dt_in(dt_pin),
      .word_in(pw), .ck_out(pck), .dt_out(pdt), .word_out(rxw), .busy_out(busy));
   task print_verdict;
      if (mismatches == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk_in) if (++cyc > 20000) begin
      mismatches++;
      print_verdict();
   end
   task chk(input logic [31:0] g, x);
      checks_done++;
      if (g !== x) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // One transfer; held until ready is sampled high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
      @(posedge mclk_in);
      pen <= 1;
      do @(posedge mclk_in); while (rdy !== 1'b1);
      {q, e} = {prd, err};
      {psel, pen} <= 2'b00;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, x);
      bus(0, a, 0);
      chk(q & m, x);
   endtask
   task poll(input int b); // Wait for an event flag, bounded
      q = 0; // A flag left in the last read data must not end the wait
      for (int n = 0; n < 100 && q[b] !== 1'b1; n++) bus(0, `SSP_OFF_IRQ_CTRL, 0);
      chk(q[b], 1); // A wait that runs out counts as a mismatch
   endtask
   initial begin
      repeat (8) @(posedge mclk_in);
      nrst_in <= 1;
      repeat (4) @(posedge mclk_in);
      rd(`SSP_OFF_IRQ_CTRL, ~0, 32'h1);
      rd(8'h20, ~0, 0);
      chk(e, 1);
      pw <= 9'h0a5;
      bus(1, `SSP_OFF_DIV_LOW, 7);
      bus(1, `SSP_OFF_XMT_STATUS, 32'h90);
      bus(1, `SSP_OFF_IRQ_CTRL, 32'he0);
      chk(cko, 0);
      bus(1, `SSP_OFF_RCV_STATUS, 32'ha0);
      poll(1);
      chk(irq, 1);
      chk(dtn, 1);
      rd(`SSP_OFF_RCV_STATUS, ~0, 32'h80);
      rd(`SSP_OFF_RCV_BUFFER, ~0, 32'ha5);
      repeat (400) @(posedge mclk_in);
      rd(`SSP_OFF_IRQ_CTRL, ~0, 32'he1);
      {pw, pol} <= {9'h15a, 1'b1};
      bus(1, `SSP_OFF_RATE_POL, 32'h10);
      repeat (50) @(posedge mclk_in);
      chk(ck_pin, 1);
      bus(1, `SSP_OFF_RCV_STATUS, 32'hf0);
      poll(1);
      rd(`SSP_OFF_RCV_STATUS, 1, 1);
      rd(`SSP_OFF_RCV_BUFFER, ~0, 32'h5a);
      poll(1);
      rd(`SSP_OFF_RCV_BUFFER, ~0, 32'h5a);
      repeat (400) @(posedge mclk_in);
      rd(`SSP_OFF_RCV_STATUS, 2, 2);
      bus(1, `SSP_OFF_RCV_STATUS, 32'h80);
      rd(`SSP_OFF_RCV_STATUS, ~0, 32'h81);
      rd(`SSP_OFF_RCV_BUFFER, ~0, 32'h5a);
      pol <= 0;
      bus(1, `SSP_OFF_RATE_POL, 0);
      bus(1, `SSP_OFF_IRQ_CTRL, 32'h10);
      bus(1, `SSP_OFF_XMT_STATUS, 32'h71);
      repeat (50) @(posedge mclk_in);
      chk(ckn, 1);
      bus(1, `SSP_OFF_XMT_BUFFER, 32'h3c);
      bus(1, `SSP_OFF_XMT_BUFFER, 32'hc3);
      rd(`SSP_OFF_IRQ_CTRL, ~0, 32'h10);
      {slp, go} <= {1'b1, ~go};
      repeat (2) @(posedge mclk_in);
      wait (!busy);
      chk(rxw, 9'h13c);
      repeat (10) @(posedge mclk_in);
      chk({wake, irq}, 2'b10);
      {slp, go} <= {1'b0, ~go};
      repeat (2) @(posedge mclk_in);
      wait (!busy);
      chk(rxw, 9'h1c3);
      rd(`SSP_OFF_IRQ_CTRL, ~0, 32'h11);
      print_verdict();
   end
endmodule // ssp_port_tb_top
